/* File: verif/dsl_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Working register file and data memory fed by the unit's results.
module dsl_core_model (
   // Clock.
   input  wire logic        clk_in,
   // Result write port.
   input  wire logic        res_valid_in,
   input  wire logic [15:0] res_data_in,
   input  wire logic [3:0]  res_dest_in,
   // Excess write port.
   input  wire logic        exc_valid_in,
   input  wire logic [15:0] exc_data_in,
   input  wire logic [3:0]  exc_dest_in,
   input  wire logic        exc_ind_in
);
   logic [15:0] wreg [16];
   logic [15:0] mem  [16];

   // An indirect excess lands in memory at the pointer held in the register.
   always @(posedge clk_in) begin
      if (res_valid_in) begin
         wreg[res_dest_in] <= res_data_in;
      end
      if (exc_valid_in && exc_ind_in) begin
         mem[wreg[exc_dest_in][3:0]] <= exc_data_in;
      end else if (exc_valid_in) begin
         wreg[exc_dest_in] <= exc_data_in;
      end
   end
endmodule // dsl_core_model

`default_nettype wire

/* File: verif/dsl_scale_limit_unit_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsl_map.svh"

// ==========================================================================
// Self-checking bench for the scaling and limit unit.
module dsl_scale_limit_unit_test;
   logic        ref_clk;
   logic        nrst;
   logic [7:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic        op_v;
   logic [3:0]  op_c;
   logic        op_a;
   logic        op_b;
   logic [15:0] op_d;
   logic [15:0] op_u;
   logic [15:0] op_l;
   logic        op_i;
   logic        rv;
   logic [15:0] rdat;
   logic [3:0]  rdst;
   logic        ev;
   logic [15:0] edat;
   logic [3:0]  edst;
   logic        eind;
   logic [3:0]  flg;
   int          error_cnt = 0;
   int          n_compared = 0;
   localparam logic [15:0] FX_IN [15] = '{16'h0001, 16'h0002, 16'h0004,
      16'h0100, 16'h01FF, 16'h0806, 16'h2007, 16'h4800, 16'h7000, 16'h8000,
      16'h900A, 16'hE001, 16'hFF07, 16'h0000, 16'hFFFF};
   localparam logic [15:0] FX_EX [15] = '{16'hFFF2, 16'hFFF3, 16'hFFF4,
      16'hFFFA, 16'hFFFA, 16'hFFFD, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'hFFFE, 16'hFFF9, 16'hFFF1, 16'hFFF1};
   localparam logic [15:0] DC_D [4] = '{16'h0100, 16'hFF00, 16'h0010, 16'h0100};
   localparam logic [15:0] DC_R [4] = '{16'h0080, 16'hFFF0, 16'h0010, 16'h0080};
   localparam logic [15:0] DC_E [4] = '{16'h0001, 16'hFFFF, 16'h0000, 16'h0000};
   localparam logic [15:0] DC_F [4] = '{16'h0001, 16'h0008, 16'h0002, 16'h0001};

   // Destination tags are fixed so the echoes can be compared directly.
   dsl_scale_limit_unit DUT (
      .ref_clk_in(ref_clk), .nrst_in(nrst), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .op_valid_in(op_v), .op_code_in(op_c),
      .op_acc_sel_in(op_a), .op_bound_acc_in(op_b), .op_operand_in(op_d),
      .op_upper_in(op_u), .op_lower_in(op_l), .op_dest_in(4'h2),
      .op_exc_dest_in(4'h7), .op_exc_ind_in(op_i), .res_valid_out(rv),
      .res_data_out(rdat), .res_dest_out(rdst), .exc_valid_out(ev),
      .exc_data_out(edat), .exc_dest_out(edst), .exc_ind_out(eind),
      .flags_out(flg));

   dsl_core_model CORE (
      .clk_in(ref_clk), .res_valid_in(rv), .res_data_in(rdat),
      .res_dest_in(rdst), .exc_valid_in(ev), .exc_data_in(edat),
      .exc_dest_in(edst), .exc_ind_in(eind));

   // Clock at 250 MHz.
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // ==========================================================================
   // Shared tasks.
   task automatic chk(input string nm, input logic [15:0] got,
                      input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask

   // Read data are valid only in the cycle after the strobe.
   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [15:0] e);
      @(posedge ref_clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd   <= 1'b0;
      #1;
      chk(nm, rdata, e);
   endtask

   // Outputs are sampled 1 ns after the edge that takes the request.
   task automatic op(input logic [3:0] c, input logic a, input logic b,
                     input logic [15:0] d, input logic [15:0] u,
                     input logic [15:0] l, input logic i);
      @(posedge ref_clk);
      op_v <= 1'b1;
      op_c <= c;
      op_a <= a;
      op_b <= b;
      op_d <= d;
      op_u <= u;
      op_l <= l;
      op_i <= i;
      @(posedge ref_clk);
      op_v <= 1'b0;
      #1;
   endtask

   task automatic set_acc(input logic b, input logic [15:0] g,
                          input logic [15:0] h, input logic [15:0] l);
      logic [7:0] o;
      o = b ? `DSL_ACC_STRIDE : 8'h00;
      wr_reg(`DSL_OFS_ACC_GU + o, g);
      wr_reg(`DSL_OFS_ACC_HI + o, h);
      wr_reg(`DSL_OFS_ACC_LO + o, l);
   endtask

   task automatic give_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs well under two thousand cycles.
   initial begin
      #40000;
      error_cnt++;
      give_verdict();
   end

   // ==========================================================================
   // Main sequence.
   initial begin
      nrst  = 1'b0;
      addr  = 8'h00;
      wdata = 16'h0000;
      wr    = 1'b0;
      rd    = 1'b0;
      op_v  = 1'b0;
      op_c  = 4'h0;
      op_a  = 1'b0;
      op_b  = 1'b0;
      op_d  = 16'h0000;
      op_u  = 16'h0000;
      op_l  = 16'h0000;
      op_i  = 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      rd_chk("status_rst", `DSL_OFS_STATUS, 16'h0000);
      rd_chk("ctrl_rst", `DSL_OFS_CTRL, 16'h0000);
      rd_chk("acc_hi_rst", `DSL_OFS_ACC_HI, 16'h0000);
      // Exponent table including both flat words.
      for (int k = 0; k < 15; k++) begin
         op(dsl_pkg::DSL_OP_FIND_EXP, 1'b0, 1'b0, FX_IN[k], 16'h0, 16'h0, 1'b0);
         chk("exp_valid", {15'h0, rv}, 16'h0001);
         chk("exp_value", rdat, FX_EX[k]);
         chk("exp_dest", {12'h0, rdst}, 16'h0002);
      end
      // Dual clamp above, below, inside; last one without report.
      for (int k = 0; k < 4; k++) begin
         op((k == 3) ? 4'h2 : 4'h3, 1'b0, 1'b0, DC_D[k], 16'h0080, 16'hFFF0,
            1'b0);
         chk("dual_res", rdat, DC_R[k]);
         chk("dual_exc_valid", {15'h0, ev}, (k == 3) ? 16'h0 : 16'h1);
         if (k < 3) chk("dual_exc", edat, DC_E[k]);
         if (k < 3) chk("dual_exc_dst", {12'h0, edst}, 16'h0007);
         chk("dual_flags", {12'h0, flg}, DC_F[k]);
      end
      chk("wreg_exc", CORE.wreg[7], 16'h0000);
      rd_chk("unmapped", 8'h40, 16'h0000);
      rd_chk("status_rd", `DSL_OFS_STATUS, 16'h0001);
      // A non-zero read must fall back to zero one cycle later.
      @(posedge ref_clk);
      #1;
      chk("rdata_idle", rdata, 16'h0000);
      // Upper clamp with indirect excess, then a bound not exceeded.
      set_acc(1'b0, 16'h0000, 16'h4000, 16'h1234);
      op(dsl_pkg::DSL_OP_UPPER_REP, 1'b0, 1'b0, 16'h2000, 16'h0, 16'h0, 1'b1);
      chk("upper_exc", edat, 16'h0001);
      chk("upper_ind", {15'h0, eind}, 16'h0001);
      chk("upper_flags", {12'h0, flg}, 16'h0001);
      @(posedge ref_clk);
      #1;
      chk("mem_exc", CORE.mem[0], 16'h0001);
      rd_chk("upper_hi", `DSL_OFS_ACC_HI, 16'h2000);
      rd_chk("upper_lo", `DSL_OFS_ACC_LO, 16'h0000);
      op(dsl_pkg::DSL_OP_UPPER, 1'b0, 1'b0, 16'h7000, 16'h0, 16'h0, 1'b0);
      chk("upper_keep_fl", {12'h0, flg}, 16'h0002);
      rd_chk("upper_keep", `DSL_OFS_ACC_HI, 16'h2000);
      // Lower clamp by a word, then by the other accumulator.
      op(dsl_pkg::DSL_OP_LOWER_REP, 1'b0, 1'b0, 16'h3000, 16'h0, 16'h0, 1'b0);
      chk("lower_exc", edat, 16'hFFFF);
      chk("lower_flags", {12'h0, flg}, 16'h0008);
      rd_chk("lower_hi", `DSL_OFS_ACC_HI, 16'h3000);
      set_acc(1'b1, 16'h0000, 16'h5000, 16'h0000);
      op(dsl_pkg::DSL_OP_LOWER, 1'b0, 1'b1, 16'h0000, 16'h0, 16'h0, 1'b0);
      rd_chk("lower_acc_hi", `DSL_OFS_ACC_HI, 16'h5000);
      // Conditional lower clamp refused while z is clear.
      op(dsl_pkg::DSL_OP_LOWER_Z, 1'b0, 1'b0, 16'h6000, 16'h0, 16'h0, 1'b0);
      chk("lower_clamp_if_zero_off_fl", {12'h0, flg}, 16'h0008);
      rd_chk("lower_clamp_if_zero_off_hi", `DSL_OFS_ACC_HI, 16'h5000);
      wr_reg(`DSL_OFS_STATUS, 16'h0002);
      op(dsl_pkg::DSL_OP_LOWER_Z, 1'b0, 1'b0, 16'h6000, 16'h0, 16'h0, 1'b0);
      chk("lower_clamp_if_zero_on_fl", {12'h0, flg}, 16'h0008);
      rd_chk("lower_clamp_if_zero_on_hi", `DSL_OFS_ACC_HI, 16'h6000);
      // Guard bits keep a left shift only in super-saturation.
      wr_reg(`DSL_OFS_CTRL, 16'h0001);
      set_acc(1'b0, 16'h0000, 16'h4000, 16'h0000);
      op(dsl_pkg::DSL_OP_ACC_SHIFT, 1'b0, 1'b0, 16'h003F, 16'h0, 16'h0, 1'b0);
      rd_chk("ssat_hi", `DSL_OFS_ACC_HI, 16'h8000);
      wr_reg(`DSL_OFS_CTRL, 16'h0000);
      set_acc(1'b0, 16'h0000, 16'h4000, 16'h0000);
      op(dsl_pkg::DSL_OP_ACC_SHIFT, 1'b0, 1'b0, 16'h003F, 16'h0, 16'h0, 1'b0);
      rd_chk("sat_hi", `DSL_OFS_ACC_HI, 16'h7FFF);
      rd_chk("sat_lo", `DSL_OFS_ACC_LO, 16'hFFFF);
      // Rounded store ignores the guard byte.
      wr_reg(`DSL_OFS_CTRL, 16'h0001);
      set_acc(1'b0, 16'h0001, 16'h1234, 16'h8000);
      op(dsl_pkg::DSL_OP_RND_STORE, 1'b0, 1'b0, 16'h0, 16'h0, 16'h0, 1'b0);
      chk("rnd_store", rdat, 16'h1235);
      set_acc(1'b0, 16'h0001, 16'h7FFF, 16'h8000);
      op(dsl_pkg::DSL_OP_RND_STORE, 1'b0, 1'b0, 16'h0, 16'h0, 16'h0, 1'b0);
      chk("rnd_hold", rdat, 16'h7FFF);
      // Normalizing by software from the guard byte.
      set_acc(1'b0, 16'h0001, 16'h0000, 16'h0000);
      op(dsl_pkg::DSL_OP_READ_GUARD, 1'b0, 1'b0, 16'h0, 16'h0, 16'h0, 1'b0);
      op(dsl_pkg::DSL_OP_FIND_EXP, 1'b0, 1'b0, rdat, 16'h0, 16'h0, 1'b0);
      chk("norm_exp", rdat, 16'hFFF2);
      op(dsl_pkg::DSL_OP_ACC_SHIFT, 1'b0, 1'b0, rdat + 16'd15, 16'h0, 16'h0,
         1'b0);
      rd_chk("norm_hi", `DSL_OFS_ACC_HI, 16'h8000);
      op(dsl_pkg::DSL_OP_READ_HIGH, 1'b0, 1'b0, 16'h0, 16'h0, 16'h0, 1'b0);
      chk("norm_high", rdat, 16'h8000);
      op(dsl_pkg::DSL_OP_READ_GUARD, 1'b0, 1'b0, 16'h0, 16'h0, 16'h0, 1'b0);
      chk("norm_guard", rdat, 16'h0000);
      give_verdict();
   end
endmodule // dsl_scale_limit_unit_test

`default_nettype wire

/* File: verilog/dsl_exp_finder.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Exponent finder: counts the leading bits below the sign that repeat the sign.
module dsl_exp_finder (
   // Operand in, negated exponent out.
   dsl_exp_if.finder x
);

   logic [15:0] match;
   logic [4:0]  cnt;

   // Each stage matches only while every stage above it matched.
   assign match[15] = 1'b1;
   genvar g;
   generate
      for (g = 0; g < 15; g++) begin : g_chain
         assign match[14-g] = match[15-g] & (x.word[14-g] == x.word[15]);
      end
   endgenerate

   // flat gives fifteen.
   // Count of leading sign copies; a flat word gives fifteen.
   always_comb begin
      cnt = 5'h00;
      for (int i = 0; i < 15; i++) begin
         cnt = cnt + {4'h0, match[i]};
      end
   end

   assign x.neg_exp = 16'h0000 - {11'h000, cnt};

endmodule // dsl_exp_finder

`default_nettype wire

/* File: verilog/dsl_exp_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Operand and result of the exponent finder.
interface dsl_exp_if;
   dsl_pkg::dsl_word_t word;
   dsl_pkg::dsl_word_t neg_exp;

   modport requester (output word, input neg_exp);
   modport finder    (input word, output neg_exp);
endinterface

`default_nettype wire

/* File: verilog/dsl_map.svh */
`ifndef DSL_MAP_SVH
`define DSL_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses on the register port).
`define DSL_OFS_STATUS   8'h00
`define DSL_OFS_CTRL     8'h04
`define DSL_OFS_ACC_LO   8'h08
`define DSL_OFS_ACC_HI   8'h0C
`define DSL_OFS_ACC_GU   8'h10
`define DSL_ACC_STRIDE   8'h0C
`define DSL_OFS_ACCB_LO  8'h14
`define DSL_OFS_ACCB_HI  8'h18
`define DSL_OFS_ACCB_GU  8'h1C

// ==========================================================================
// Field positions and reset values.
`define DSL_CTRL_SSAT    0
`define DSL_STATUS_RST   4'h0
`define DSL_CTRL_RST     1'h0
`define DSL_ACC_RST      40'h00_0000_0000

// ==========================================================================
// Datapath constants.
`define DSL_SAT_POS      40'h00_7FFF_FFFF
`define DSL_SAT_NEG      40'hFF_8000_0000
`define DSL_RND_MAX      16'h7FFF
`define DSL_EXC_POS      16'h0001
`define DSL_EXC_NEG      16'hFFFF
`define DSL_EXC_NONE     16'h0000
`define DSL_EXP_FLAT     16'hFFF1

`endif

/* File: verilog/dsl_pkg.sv */
// ==========================================================================
// Types shared by the scaling and limit unit.
package dsl_pkg;

   // Operation codes presented by the instruction decoder.
   typedef enum logic [3:0] {
      DSL_OP_NONE       = 4'h0,
      DSL_OP_FIND_EXP   = 4'h1,
      DSL_OP_DUAL       = 4'h2,
      DSL_OP_DUAL_REP   = 4'h3,
      DSL_OP_UPPER      = 4'h4,
      DSL_OP_UPPER_REP  = 4'h5,
      DSL_OP_LOWER      = 4'h6,
      DSL_OP_LOWER_REP  = 4'h7,
      DSL_OP_LOWER_Z    = 4'h8,
      DSL_OP_ACC_SHIFT  = 4'h9,
      DSL_OP_RND_STORE  = 4'hA,
      DSL_OP_READ_GUARD = 4'hB,
      DSL_OP_READ_HIGH  = 4'hC
   } dsl_op_e;

   typedef logic [39:0] dsl_acc_t;
   typedef logic [15:0] dsl_word_t;

   // Status flags, packed so that n is bit 3 and c is bit 0.
   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic c;
   } dsl_flags_s;

endpackage

/* File: verilog/dsl_scale_limit_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsl_map.svh"

// ==========================================================================
// Scaling and range limit unit of the DSP datapath.
module dsl_scale_limit_unit (
   // Clock and reset.
   input  wire logic        ref_clk_in,
   input  wire logic        nrst_in,
   // Register port.
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [15:0] reg_rdata_out,
   // Operation request from the decoder.
   input  wire logic        op_valid_in,
   input  wire logic [3:0]  op_code_in,
   input  wire logic        op_acc_sel_in,
   input  wire logic        op_bound_acc_in,
   input  wire logic [15:0] op_operand_in,
   input  wire logic [15:0] op_upper_in,
   input  wire logic [15:0] op_lower_in,
   input  wire logic [3:0]  op_dest_in,
   input  wire logic [3:0]  op_exc_dest_in,
   input  wire logic        op_exc_ind_in,
   // Results back to the register file.
   output logic             res_valid_out,
   output logic      [15:0] res_data_out,
   output logic      [3:0]  res_dest_out,
   output logic             exc_valid_out,
   output logic      [15:0] exc_data_out,
   output logic      [3:0]  exc_dest_out,
   output logic             exc_ind_out,
   output logic      [3:0]  flags_out
);

   // =======================================================================
   // Decoding helpers.
   // Operations that compare against a bound and touch the flags.
   function automatic logic is_limit(input dsl_pkg::dsl_op_e c);
      return (c == dsl_pkg::DSL_OP_DUAL) || (c == dsl_pkg::DSL_OP_DUAL_REP)
          || (c == dsl_pkg::DSL_OP_UPPER) || (c == dsl_pkg::DSL_OP_UPPER_REP)
          || (c == dsl_pkg::DSL_OP_LOWER) || (c == dsl_pkg::DSL_OP_LOWER_REP)
          || (c == dsl_pkg::DSL_OP_LOWER_Z);
   endfunction

   // Operations that also hand back a limit excess.
   function automatic logic is_report(input dsl_pkg::dsl_op_e c);
      return (c == dsl_pkg::DSL_OP_DUAL_REP)
          || (c == dsl_pkg::DSL_OP_UPPER_REP)
          || (c == dsl_pkg::DSL_OP_LOWER_REP);
   endfunction

   // =======================================================================
   // State.
   dsl_pkg::dsl_acc_t   acc [0:1];
   dsl_pkg::dsl_flags_s flags;
   logic                ssat;
   dsl_pkg::dsl_op_e    code;
   dsl_pkg::dsl_acc_t   tgt, oth, bnd, shifted, next_acc;
   dsl_pkg::dsl_word_t  next_res, next_exc;
   dsl_pkg::dsl_flags_s next_flags;
   logic                run, acc_wr, res_wr;
   logic                up_hit, lo_hit, w_up, w_lo;
   logic signed [5:0]   amt;
   logic [15:0]         rnd_hi;

   assign code = dsl_pkg::dsl_op_e'(op_code_in);

   // =======================================================================
   // Exponent finder.
   dsl_exp_if exp_bus ();
   assign exp_bus.word = op_operand_in;
   dsl_exp_finder u_exp (
      .x (exp_bus)
   );

   // =======================================================================
   // Operation datapath.
   // The working register bound sits in the high word, sign-extended
   // into the guard byte, so it lines up with the 1.15 value it models.
   assign tgt = acc[op_acc_sel_in];
   assign oth = acc[~op_acc_sel_in];
   assign bnd = op_bound_acc_in ? oth
                : {{8{op_operand_in[15]}}, op_operand_in, 16'h0000};
   assign up_hit = $signed(tgt) > $signed(bnd);
   assign lo_hit = $signed(tgt) < $signed(bnd);
   assign w_up = $signed(op_operand_in) > $signed(op_upper_in);
   assign w_lo = $signed(op_operand_in) < $signed(op_lower_in);
   assign amt = $signed(op_operand_in[5:0]);
   assign rnd_hi = tgt[31:16];

   // Next values for every destination of the requested operation.
   always_comb begin
      next_acc = tgt;
      next_res = 16'h0000;
      next_exc = `DSL_EXC_NONE;
      acc_wr = 1'b0;
      res_wr = 1'b0;
      shifted = tgt;
      run = op_valid_in
            && !((code == dsl_pkg::DSL_OP_LOWER_Z) && !flags.z);
      case (code)
         dsl_pkg::DSL_OP_FIND_EXP: begin
            next_res = exp_bus.neg_exp;
            res_wr = 1'b1;
         end
         dsl_pkg::DSL_OP_DUAL, dsl_pkg::DSL_OP_DUAL_REP: begin
            res_wr = 1'b1;
            if (w_up) begin
               next_res = op_upper_in;
               next_exc = `DSL_EXC_POS;
            end else if (w_lo) begin
               next_res = op_lower_in;
               next_exc = `DSL_EXC_NEG;
            end else begin
               next_res = op_operand_in;
            end
         end
         dsl_pkg::DSL_OP_UPPER, dsl_pkg::DSL_OP_UPPER_REP: begin
            acc_wr = 1'b1;
            if (up_hit) begin
               next_acc = bnd;
               next_exc = `DSL_EXC_POS;
            end
         end
         dsl_pkg::DSL_OP_LOWER, dsl_pkg::DSL_OP_LOWER_REP,
         dsl_pkg::DSL_OP_LOWER_Z: begin
            acc_wr = 1'b1;
            if (lo_hit) begin
               next_acc = bnd;
               next_exc = `DSL_EXC_NEG;
            end
         end
         dsl_pkg::DSL_OP_ACC_SHIFT: begin
            // Negative amounts shift left; bits pushed past bit 39 are lost.
            acc_wr = 1'b1;
            if (amt < 0) begin
               shifted = tgt << 6'(-amt);
            end else begin
               shifted = dsl_pkg::dsl_acc_t'($signed(tgt) >>> amt);
            end
            if (!ssat && $signed(shifted) > $signed(`DSL_SAT_POS)) begin
               next_acc = `DSL_SAT_POS;
            end else if (!ssat
                         && $signed(shifted) < $signed(`DSL_SAT_NEG)) begin
               next_acc = `DSL_SAT_NEG;
            end else begin
               next_acc = shifted;
            end
         end
         dsl_pkg::DSL_OP_RND_STORE: begin
            res_wr = 1'b1;
            if (rnd_hi == `DSL_RND_MAX) begin
               next_res = `DSL_RND_MAX;
            end else begin
               next_res = rnd_hi + {15'h0000, tgt[15]};
            end
         end
         dsl_pkg::DSL_OP_READ_GUARD: begin
            // guard byte, sign-extended to a word.
            res_wr = 1'b1;
            next_res = {{8{tgt[39]}}, tgt[39:32]};
         end
         dsl_pkg::DSL_OP_READ_HIGH: begin
            res_wr = 1'b1;
            next_res = tgt[31:16];
         end
         default: res_wr = 1'b0;
      endcase
      next_flags.n = (next_exc == `DSL_EXC_NEG);
      next_flags.ov = 1'b0;
      next_flags.z = (next_exc == `DSL_EXC_NONE);
      next_flags.c = (next_exc == `DSL_EXC_POS);
   end

   // =======================================================================
   // Accumulators; an operation wins over a register write that collides.
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_acc
         localparam logic [7:0] BASE = 8'(g) * `DSL_ACC_STRIDE;
         always_ff @(posedge ref_clk_in) begin
            if (!nrst_in) begin
               acc[g] <= `DSL_ACC_RST;
            end else if (run && acc_wr && (op_acc_sel_in == 1'(g))) begin
               acc[g] <= next_acc;
            end else if (reg_wr_in) begin
               if (reg_addr_in == `DSL_OFS_ACC_LO + BASE) begin
                  acc[g][15:0] <= reg_wdata_in;
               end else if (reg_addr_in == `DSL_OFS_ACC_HI + BASE) begin
                  acc[g][31:16] <= reg_wdata_in;
               end else if (reg_addr_in == `DSL_OFS_ACC_GU + BASE) begin
                  acc[g][39:32] <= reg_wdata_in[7:0];
               end
            end
         end
      end
   endgenerate

   // =======================================================================
   // Status flags; a limit operation beats a software write.
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         flags <= dsl_pkg::dsl_flags_s'(`DSL_STATUS_RST);
      end else if (run && is_limit(code)) begin
         flags <= next_flags;
      end else if (reg_wr_in && reg_addr_in == `DSL_OFS_STATUS) begin
         flags <= dsl_pkg::dsl_flags_s'(reg_wdata_in[3:0]);
      end
   end
   assign flags_out = flags;

   // Super-saturation enable; when clear, shifts saturate to 1.31.
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         ssat <= `DSL_CTRL_RST;
      end else if (reg_wr_in && reg_addr_in == `DSL_OFS_CTRL) begin
         ssat <= reg_wdata_in[`DSL_CTRL_SSAT];
      end
   end

   // =======================================================================
   // Register read port: data stand in the cycle after the strobe only.
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in || !reg_rd_in) begin
         reg_rdata_out <= 16'h0000;
      end else begin
         case (reg_addr_in)
            `DSL_OFS_STATUS:  reg_rdata_out <= {12'h000, flags};
            `DSL_OFS_CTRL:    reg_rdata_out <= {15'h0000, ssat};
            `DSL_OFS_ACC_LO:  reg_rdata_out <= acc[0][15:0];
            `DSL_OFS_ACC_HI:  reg_rdata_out <= acc[0][31:16];
            `DSL_OFS_ACC_GU:  reg_rdata_out <= {8'h00, acc[0][39:32]};
            `DSL_OFS_ACCB_LO: reg_rdata_out <= acc[1][15:0];
            `DSL_OFS_ACCB_HI: reg_rdata_out <= acc[1][31:16];
            `DSL_OFS_ACCB_GU: reg_rdata_out <= {8'h00, acc[1][39:32]};
            default:          reg_rdata_out <= 16'h0000;
         endcase
      end
   end

   // =======================================================================
   // Result and excess outputs, one cycle after the request.
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         res_valid_out <= 1'b0;
         res_data_out <= 16'h0000;
         res_dest_out <= 4'h0;
      end else begin
         res_valid_out <= run && res_wr;
         if (run && res_wr) begin
            res_data_out <= next_res;
            res_dest_out <= op_dest_in;
         end
      end
   end
   // Excess data hold their last value; only the strobe is a pulse.
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         exc_valid_out <= 1'b0;
         exc_data_out <= `DSL_EXC_NONE;
         exc_dest_out <= 4'h0;
         exc_ind_out <= 1'b0;
      end else begin
         exc_valid_out <= run && is_report(code);
         if (run && is_report(code)) begin
            exc_data_out <= next_exc;
            exc_dest_out <= op_exc_dest_in;
            exc_ind_out <= op_exc_ind_in;
         end
      end
   end

   // =======================================================================
   // Checks.
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_req(dsl_pkg::dsl_op_e c);
      op_valid_in && code == c;
   endsequence
   sequence s_flat_req;
      op_valid_in && code == dsl_pkg::DSL_OP_FIND_EXP
      && (op_operand_in == 16'h0000 || op_operand_in == 16'hFFFF);
   endsequence

   AST_EXP_RANGE: assert property (
      s_req(dsl_pkg::DSL_OP_FIND_EXP) |=> res_valid_out
      && ($signed(res_data_out) <= 0) && ($signed(res_data_out) >= -15))
      else $error("exponent out of range");
   AST_EXP_FLAT: assert property (
      s_flat_req |=> res_data_out == `DSL_EXP_FLAT)
      else $error("flat word did not give -15");
   AST_EXP_NORM: assert property (
      op_valid_in && code == dsl_pkg::DSL_OP_FIND_EXP
      && op_operand_in != 16'h0000 && op_operand_in != 16'hFFFF |=>
      (($past(op_operand_in) << (16'h0000 - res_data_out)) >> 14)
      == {14'h0000, $past(op_operand_in[15]), !$past(op_operand_in[15])})
      else $error("shift by result does not normalise");
   AST_DUAL: assert property (
      op_valid_in && code == dsl_pkg::DSL_OP_DUAL
      && $signed(op_lower_in) <= $signed(op_upper_in) |=>
      $signed(res_data_out) <= $signed($past(op_upper_in))
      && $signed(res_data_out) >= $signed($past(op_lower_in)))
      else $error("dual clamp left the range");
   AST_DUAL_REP: assert property (
      s_req(dsl_pkg::DSL_OP_DUAL_REP) |=> exc_valid_out && res_valid_out
      && exc_dest_out == $past(op_exc_dest_in))
      else $error("dual clamp excess missing");
   AST_UPPER: assert property (
      s_req(dsl_pkg::DSL_OP_UPPER) |=>
      acc[$past(op_acc_sel_in)] == ($past(up_hit) ? $past(bnd) : $past(tgt)))
      else $error("upper clamp wrong");
   AST_LOWER: assert property (
      s_req(dsl_pkg::DSL_OP_LOWER) |=>
      $signed(acc[$past(op_acc_sel_in)]) >= $signed($past(bnd)))
      else $error("lower clamp left value below bound");
   AST_EXC_VAL: assert property (
      s_req(dsl_pkg::DSL_OP_UPPER_REP) ##1 exc_valid_out |->
      exc_data_out == ($past(up_hit) ? `DSL_EXC_POS : `DSL_EXC_NONE))
      else $error("upper excess value wrong");
   AST_FLAGS: assert property (
      op_valid_in && is_limit(code) && run |=>
      flags.z == ($past(next_exc) == `DSL_EXC_NONE) && !flags.ov)
      else $error("flags do not match excess");
   AST_LOWER_CLAMP_IF_ZERO_HOLD: assert property (
      op_valid_in && code == dsl_pkg::DSL_OP_LOWER_Z && !flags.z
      && !reg_wr_in |=> $stable(flags) && $stable(acc[0]) && $stable(acc[1]))
      else $error("conditional clamp ran with zero clear");
   AST_RND: assert property (
      s_req(dsl_pkg::DSL_OP_RND_STORE) |=> res_valid_out
      && (res_data_out - $past(rnd_hi)) <= 16'h0001)
      else $error("rounded store not from high word");

endmodule // dsl_scale_limit_unit

`default_nettype wire
